// ==== ssm_pkg.sv ====
`default_nettype none
package ssm_pkg;
	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL  = 8'h00; // port_control_one
	localparam logic [7:0] OFS_BAUD  = 8'h04; // baud_reload_value
	localparam logic [7:0] OFS_BUF   = 8'h08; // transfer_buffer
	localparam logic [7:0] OFS_STAT  = 8'h0c; // port_status_reg
	localparam logic [7:0] OFS_ISTAT = 8'h10; // sticky events, read only
	localparam logic [7:0] OFS_ICLR  = 8'h14; // write one to clear, write only
	localparam logic [7:0] OFS_IEN   = 8'h18; // event enables

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CTRL_CPOL    = 0; // clock_idle_polarity
	localparam int CTRL_CKE     = 1; // clock edge select
	localparam int CTRL_SPH     = 2; // input_sample_phase
	localparam int CTRL_SDO_DIS = 3; // serial output released
	localparam int CTRL_RATE_LO = 4; // rate select, three bits
	localparam int STAT_BUSY    = 0;
	localparam int STAT_FULL    = 1;
	localparam int EV_DONE      = 0; // byte completed
	localparam int EV_COLL      = 1; // buffer written while busy

	// ------------------------------------------------------------
	// reset values and encodings
	// ------------------------------------------------------------
	localparam logic [6:0] CTRL_RST = 7'h00;
	localparam logic [7:0] BAUD_RST = 8'h00;
	localparam logic [2:0] RATE_DIV4  = 3'h0;
	localparam logic [2:0] RATE_DIV16 = 3'h1;
	localparam logic [2:0] RATE_DIV64 = 3'h2;
	localparam logic [2:0] RATE_TMR   = 3'h3;
	localparam logic [2:0] RATE_BAUD  = 3'h4;

	// ------------------------------------------------------------
	// timing: half bit periods in system clocks, and frame length
	// ------------------------------------------------------------
	localparam logic [9:0] HALF_DIV4  = 10'h002;
	localparam logic [9:0] HALF_DIV16 = 10'h008;
	localparam logic [9:0] HALF_DIV64 = 10'h020;
	localparam logic [4:0] EDGES      = 5'h10; // sixteen edges, eight pulses

	typedef enum logic [1:0] {
		SSM_IDLE  = 2'b01,
		SSM_SHIFT = 2'b10
	} ssm_state_e;
endpackage
`default_nettype wire

// ==== ssm_rate_if.sv ====
`default_nettype none
interface ssm_rate_if;
	logic       ce;
	logic       run;
	logic [2:0] rate_sel;
	logic [7:0] reload;
	logic       timer_tick;
	logic       tick;

	modport gen  (input ce, run, rate_sel, reload, timer_tick, output tick);
	modport user (output ce, run, rate_sel, reload, timer_tick, input tick);
endinterface
`default_nettype wire

// ==== ssm_rate.sv ====
`default_nettype none
module ssm_rate (
	input  wire logic   clk_i,
	input  wire logic   reset_n_i,
	ssm_rate_if.gen     r_if
);
	// ------------------------------------------------------------
	// half bit period generator
	// ------------------------------------------------------------
	logic [9:0] cnt_r;
	logic [9:0] cnt_nxt;
	logic       tick_r;
	logic       tick_nxt;
	logic [9:0] limit;

	// baud reload gives a bit of 4*(n+1) clocks, so a half of 2*(n+1)
	always_comb begin
		unique case (r_if.rate_sel)
			ssm_pkg::RATE_DIV16: limit = ssm_pkg::HALF_DIV16;
			ssm_pkg::RATE_DIV64: limit = ssm_pkg::HALF_DIV64;
			ssm_pkg::RATE_BAUD:  limit = {1'b0, r_if.reload, 1'b0} + 10'h002;
			default:             limit = ssm_pkg::HALF_DIV4; // unused codes fall back
		endcase
	end

	// counter restarts whenever no frame runs, so the first half is whole
	always_comb begin
		cnt_nxt  = 10'h000;
		tick_nxt = 1'b0;
		if (r_if.run) begin
			if (r_if.rate_sel == ssm_pkg::RATE_TMR) begin
				tick_nxt = r_if.timer_tick; // each timer pulse is half a bit
			end else if (cnt_r >= limit - 10'h001) begin
				tick_nxt = 1'b1;
			end else begin
				cnt_nxt = cnt_r + 10'h001;
			end
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cnt_r  <= 10'h000;
			tick_r <= 1'b0;
		end else if (r_if.ce) begin
			cnt_r  <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign r_if.tick = tick_r;
endmodule
`default_nettype wire

// ==== ssm_top.sv ====
// Function
// - master may start a transfer whenever it is idle; it alone drives the clock.
// - writing the transfer buffer starts shifting out and in at once.
// - serial output can be released for receive-only use.
// - input keeps being sampled at the bit rate whether output is used.
// - each finished byte goes to the buffer and sets flags.
// - clock idle level follows polarity bit; shifting edge follows edge select.
// - bytes travel most significant bit first both ways.
// - rate is clk/4, /16, /64, timer/2 or clk/(4*(reload+1)).
// - with edge select set, output data is valid before the first edge.
// - input sample point within the bit follows the sample phase bit.
`default_nettype none
module ssm_top (
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	input  wire logic        ce_i,
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic        hready_i,
	input  wire logic [31:0] hwdata_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	output logic             sck_o,
	output logic             sdo_o,
	output logic             sdo_oe_n_o,
	input  wire logic        sdi_i,
	input  wire logic        timer_tick_i,
	output logic             irq_o
);
	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	ssm_rate_if r_if ();

	logic              wph_r, wph_nxt;
	logic [7:0]        addr_r, addr_nxt;
	logic [31:0]       rdata_r, rdata_nxt;
	logic              rd_buf;
	logic              acc;
	logic [6:0]        ctrl_r, ctrl_nxt;
	logic [7:0]        baud_r, baud_nxt;
	logic [1:0]        ien_r, ien_nxt;
	logic [1:0]        istat_r, istat_nxt;
	logic              irq_r, irq_nxt;
	ssm_pkg::ssm_state_e state_r, state_nxt;
	logic [4:0]        cnt_r, cnt_nxt;
	logic [7:0]        txr_r, txr_nxt;
	logic [7:0]        rx_r, rx_nxt;
	logic [7:0]        buf_r, buf_nxt;
	logic              full_r, full_nxt;
	logic              sck_r, sck_nxt;
	logic              sdo_r, sdo_nxt;
	logic              wr_buf, busy, cke, sph, cpol;
	logic              samp, fin, ev_coll;
	logic [4:0]        e, p;
	logic [7:0]        rx_s;

	assign busy = (state_r == ssm_pkg::SSM_SHIFT);
	assign cpol = ctrl_r[ssm_pkg::CTRL_CPOL];
	assign cke  = ctrl_r[ssm_pkg::CTRL_CKE];
	assign sph  = ctrl_r[ssm_pkg::CTRL_SPH];

	// ------------------------------------------------------------
	// register readback
	// ------------------------------------------------------------
	// next values are read, so a read right behind a write already sees it
	function automatic logic [31:0] reg_read(input logic [7:0] a);
		logic [31:0] d;
		d = 32'h0000_0000;
		unique case (a)
			ssm_pkg::OFS_CTRL:  d = {25'h0, ctrl_nxt};
			ssm_pkg::OFS_BAUD:  d = {24'h0, baud_nxt};
			ssm_pkg::OFS_BUF:   d = {24'h0, buf_nxt};
			ssm_pkg::OFS_STAT:  d = {30'h0, full_nxt, state_nxt == ssm_pkg::SSM_SHIFT};
			ssm_pkg::OFS_ISTAT: d = {30'h0, istat_nxt};
			ssm_pkg::OFS_IEN:   d = {30'h0, ien_nxt};
			default:            d = 32'h0000_0000; // unmapped and write-only read zero
		endcase
		return d;
	endfunction

	// ------------------------------------------------------------
	// AHB-Lite slave, zero wait states, always OKAY
	// ------------------------------------------------------------
	// read data is captured in the address phase so hrdata is a flop
	assign acc = hsel_i && hready_i && htrans_i[1];
	assign rd_buf = acc && !hwrite_i && (haddr_i[7:0] == ssm_pkg::OFS_BUF)
		&& (haddr_i[31:8] == 24'h0);

	always_comb begin
		wph_nxt   = acc && hwrite_i;
		addr_nxt  = addr_r;
		rdata_nxt = rdata_r;
		if (acc) begin
			addr_nxt = (haddr_i[31:8] == 24'h0) ? haddr_i[7:0] : 8'hff;
			if (!hwrite_i) begin
				rdata_nxt = (haddr_i[31:8] == 24'h0) ? reg_read(haddr_i[7:0]) : 32'h0;
			end
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wph_r   <= 1'b0;
			addr_r  <= 8'h00;
			rdata_r <= 32'h0000_0000;
		end else if (ce_i) begin
			wph_r   <= wph_nxt;
			addr_r  <= addr_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign hrdata_o    = rdata_r;
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;
	assign wr_buf      = wph_r && (addr_r == ssm_pkg::OFS_BUF);

	// ------------------------------------------------------------
	// configuration and interrupt registers
	// ------------------------------------------------------------
	// a new event wins over a clear written in the same cycle
	always_comb begin
		ctrl_nxt  = ctrl_r;
		baud_nxt  = baud_r;
		ien_nxt   = ien_r;
		istat_nxt = istat_r;
		if (wph_r && addr_r == ssm_pkg::OFS_CTRL) ctrl_nxt = hwdata_i[6:0];
		if (wph_r && addr_r == ssm_pkg::OFS_BAUD) baud_nxt = hwdata_i[7:0];
		if (wph_r && addr_r == ssm_pkg::OFS_IEN)  ien_nxt  = hwdata_i[1:0];
		if (wph_r && addr_r == ssm_pkg::OFS_ICLR) istat_nxt = istat_r & ~hwdata_i[1:0];
		if (fin)     istat_nxt[ssm_pkg::EV_DONE] = 1'b1;
		if (ev_coll) istat_nxt[ssm_pkg::EV_COLL] = 1'b1;
		irq_nxt = |(istat_nxt & ien_nxt);
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ctrl_r  <= ssm_pkg::CTRL_RST;
			baud_r  <= ssm_pkg::BAUD_RST;
			ien_r   <= 2'h0;
			istat_r <= 2'h0;
			irq_r   <= 1'b0;
		end else if (ce_i) begin
			ctrl_r  <= ctrl_nxt;
			baud_r  <= baud_nxt;
			ien_r   <= ien_nxt;
			istat_r <= istat_nxt;
			irq_r   <= irq_nxt;
		end
	end

	assign irq_o = irq_r;

	// ------------------------------------------------------------
	// bit rate generator
	// ------------------------------------------------------------
	assign r_if.ce         = ce_i;
	assign r_if.run        = busy;
	assign r_if.rate_sel   = ctrl_r[ssm_pkg::CTRL_RATE_LO +: 3];
	assign r_if.reload     = baud_r;
	assign r_if.timer_tick = timer_tick_i;

	ssm_rate u_rate (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.r_if      (r_if.gen)
	);

	// ------------------------------------------------------------
	// shift engine
	// ------------------------------------------------------------
	// e numbers the half-bit ticks; p shifts it so that even p is always
	// the point where the output bit changes, whatever the edge select
	assign e    = cnt_r + 5'h01;
	assign p    = cke ? e : e - 5'h01;
	assign samp = busy && r_if.tick && (sph ? (!p[0] && p >= 5'h02) : p[0]);
	assign fin  = busy && r_if.tick && (p == ssm_pkg::EDGES);
	assign rx_s = samp ? {rx_r[6:0], sdi_i} : rx_r;
	assign ev_coll = wr_buf && busy; // write while shifting is dropped

	// settings are read live: change them only while idle
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		txr_nxt   = txr_r;
		rx_nxt    = rx_r;
		buf_nxt   = buf_r;
		full_nxt  = full_r && !rd_buf;
		sck_nxt   = sck_r;
		sdo_nxt   = sdo_r;
		unique case (state_r)
			ssm_pkg::SSM_IDLE: begin
				sck_nxt = cpol;
				if (wr_buf) begin
					state_nxt = ssm_pkg::SSM_SHIFT;
					cnt_nxt   = 5'h00;
					rx_nxt    = 8'h00;
					if (cke) begin
						sdo_nxt = hwdata_i[7];
						txr_nxt = {hwdata_i[6:0], 1'b0};
					end else begin
						txr_nxt = hwdata_i[7:0];
					end
				end
			end
			ssm_pkg::SSM_SHIFT: begin
				if (r_if.tick) begin
					cnt_nxt = e;
					rx_nxt  = rx_s;
					if (e <= ssm_pkg::EDGES) sck_nxt = ~sck_r;
					if (!p[0] && p < ssm_pkg::EDGES) begin
						sdo_nxt = txr_r[7];
						txr_nxt = {txr_r[6:0], 1'b0};
					end
					if (fin) begin
						state_nxt = ssm_pkg::SSM_IDLE;
						buf_nxt   = rx_s;
						full_nxt  = 1'b1;
						sck_nxt   = cpol;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_r <= ssm_pkg::SSM_IDLE;
			cnt_r   <= 5'h00;
			txr_r   <= 8'h00;
			rx_r    <= 8'h00;
			buf_r   <= 8'h00;
			full_r  <= 1'b0;
			sck_r   <= 1'b0;
			sdo_r   <= 1'b0;
		end else if (ce_i) begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			txr_r   <= txr_nxt;
			rx_r    <= rx_nxt;
			buf_r   <= buf_nxt;
			full_r  <= full_nxt;
			sck_r   <= sck_nxt;
			sdo_r   <= sdo_nxt;
		end
	end

	assign sck_o      = sck_r;
	assign sdo_o      = sdo_r;
	assign sdo_oe_n_o = ctrl_r[ssm_pkg::CTRL_SDO_DIS];

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	logic [4:0] edge_cnt_r, edge_cnt_nxt;
	logic [3:0] samp_cnt_r, samp_cnt_nxt;

	// helper counters of clock toggles and samples per frame
	always_comb begin
		edge_cnt_nxt = (busy && sck_nxt != sck_r) ? edge_cnt_r + 5'h01 : edge_cnt_r;
		samp_cnt_nxt = samp ? samp_cnt_r + 4'h1 : samp_cnt_r;
		if (!busy) begin
			edge_cnt_nxt = 5'h00;
			samp_cnt_nxt = 4'h0;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			edge_cnt_r <= 5'h00;
			samp_cnt_r <= 4'h0;
		end else if (ce_i) begin
			edge_cnt_r <= edge_cnt_nxt;
			samp_cnt_r <= samp_cnt_nxt;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i || !ce_i);

	chk_start_busy: assert property (wr_buf && !busy |=> busy)
		else $error("buffer write did not start a transfer");
	chk_start_any: assert property (!busy && wr_buf |=> sck_o == $past(cpol))
		else $error("clock moved before the frame began");
	chk_sdo_off: assert property (ctrl_r[ssm_pkg::CTRL_SDO_DIS] |-> sdo_oe_n_o)
		else $error("serial output driven while released");
	chk_idle_level: assert property (!busy && !$past(busy) |-> sck_o == $past(cpol))
		else $error("clock not at idle polarity");
	chk_eight_pulses: assert property (fin |-> edge_cnt_nxt == ssm_pkg::EDGES)
		else $error("frame did not carry sixteen clock edges");
	chk_eight_samples: assert property (fin |-> samp_cnt_nxt == 4'h8)
		else $error("frame did not take eight samples");
	chk_msb_first: assert property (wr_buf && !busy && cke |=> sdo_o == $past(hwdata_i[7])
		&& sck_o == $past(cpol))
		else $error("first bit not valid before first edge");
	chk_done_flags: assert property (fin |=> full_r && istat_r[ssm_pkg::EV_DONE]
		&& buf_r == $past(rx_s) && !busy)
		else $error("completed byte not delivered");
	chk_rate_fast: assert property (busy && r_if.tick && !fin
		&& r_if.rate_sel == ssm_pkg::RATE_DIV4 |=> !r_if.tick ##1 r_if.tick)
		else $error("clk/4 rate spacing wrong");

	cov_cke_frame: cover property (fin && cke);
	cov_late_sample: cover property (fin && !cke && sph);
	cov_collision: cover property (ev_coll);
	cov_irq: cover property ($rose(irq_o));
endmodule
`default_nettype wire

// ==== ssm_slave_model.sv ====
`default_nettype none
// ------------------------------------------------------------
// far-side slave: follows the master clock, no clock of its own
// ------------------------------------------------------------
module ssm_slave_model (
	input  wire logic       clk_i,
	input  wire logic       reset_n_i,
	input  wire logic       active_i,
	input  wire logic       cke_i,
	input  wire logic       sck_i,
	input  wire logic       sdo_i,
	input  wire logic [7:0] tx_i,
	output logic            sdi_o,
	output logic      [7:0] rx_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       psck;
	logic [4:0] edges;
	logic       junk;
	int         idx;

	// count clock edges; capture on the edge the master does not launch on
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			psck  <= 1'b0;
			edges <= 5'h00;
			rx_o  <= 8'h00;
			junk  <= 1'b0;
		end else begin
			psck <= sck_i;
			junk <= ~junk; // unselected line must not look stable
			if (!active_i) begin
				edges <= 5'h00;
			end else if (sck_i != psck) begin
				edges <= edges + 5'h01;
				if ((edges[0] == 1'b0) == cke_i) begin
					rx_o <= {rx_o[6:0], sdo_i};
				end
			end
		end
	end

	// present the bit that matches the edge count, msb first
	always_comb begin
		if (cke_i) begin
			idx = 7 - int'(edges) / 2;
		end else begin
			idx = (edges == 5'h00) ? 7 : 7 - (int'(edges) - 1) / 2;
		end
		if (idx < 0) begin
			idx = 0;
		end
		sdi_o = active_i ? tx_i[idx] : junk;
	end
endmodule
`default_nettype wire

// ==== spi_master_transfer_tb.sv ====
`default_nettype none
module spi_master_transfer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// stimulus and observed signals
	// ------------------------------------------------------------
	logic        clk_i = 1'b0;
	logic        reset_n_i = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic        tick = 1'b0;
	logic        frm = 1'b0;
	logic        cke = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hready, hresp, sck, sdo, oe_n, irq, sdi, psck, sdo1;
	logic [7:0]  srx;
	logic [7:0]  stx = 8'h00;
	logic [31:0] seed = 32'h0001_39e6;
	int          failures = 0;
	int          num_checks = 0;
	int          cyc = 0;
	int          tog = 0;
	int          t1 = 0;
	int          t2 = 0;

	always #10 clk_i = ~clk_i;

	// timer pulse every third cycle, and an edge monitor on the serial clock
	always @(posedge clk_i) begin
		cyc  <= cyc + 1;
		tick <= (cyc % 3 == 0);
		psck <= sck;
		if (!frm) begin
			tog <= 0;
		end else if (sck !== psck) begin
			tog <= tog + 1;
			if (tog == 0) begin
				t1   <= cyc;
				sdo1 <= sdo;
			end
			if (tog == 1) begin
				t2 <= cyc;
			end
		end
	end

	ssm_top i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(1'b1), .hsel_i(hsel),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
		.hready_i(hready), .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hready),
		.hresp_o(hresp), .sck_o(sck), .sdo_o(sdo), .sdo_oe_n_o(oe_n), .sdi_i(sdi),
		.timer_tick_i(tick), .irq_o(irq));

	ssm_slave_model i_slave (.clk_i(clk_i), .reset_n_i(reset_n_i), .active_i(frm),
		.cke_i(cke), .sck_i(sck), .sdo_i(sdo), .tx_i(stx), .sdi_o(sdi), .rx_o(srx));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// expected half bit in system clocks; timer pulses come every 3 cycles
	function automatic int half(input logic [2:0] r, input logic [7:0] b);
		case (r)
			ssm_pkg::RATE_DIV16: return int'(ssm_pkg::HALF_DIV16);
			ssm_pkg::RATE_DIV64: return int'(ssm_pkg::HALF_DIV64);
			ssm_pkg::RATE_TMR:   return 3;
			ssm_pkg::RATE_BAUD:  return 2 * (int'(b) + 1);
			default:             return int'(ssm_pkg::HALF_DIV4);
		endcase
	endfunction

	task automatic finish_test();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask

	// wait for hready at a rising edge, bounded
	task automatic hw();
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (hready !== 1'b1 && n < 50);
		if (hready !== 1'b1) begin
			failures++;
			finish_test();
		end
	endtask

	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= {24'h0, a};
		hwrite <= w;
		hw();
		htrans <= 2'h0;
		hwdata <= d;
		hw();
		r = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		ahb(1'b1, a, d, x);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		ahb(1'b0, a, 32'h0, r);
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		logic [31:0] s;
		logic [7:0]  tx, bd;
		logic [2:0]  rate;
		logic        pol, sph, dis;
		int          n;
		repeat (6) @(posedge clk_i);
		reset_n_i <= 1'b1;
		@(posedge clk_i);
		chk("sck reset", 32'h0, {31'h0, sck});
		rd(ssm_pkg::OFS_CTRL, s);
		chk("ctrl reset", 32'h0, s);
		wr(8'h40, 32'hffff_ffff); // unmapped write is ignored
		rd(8'h40, s);
		chk("unmapped", 32'h0, s);
		for (int i = 0; i < 12; i++) begin
			s    = rnd();
			rate = 3'(i % 5);
			pol  = s[0];
			sph  = s[2];
			dis  = (i == 2);
			bd   = {6'h0, s[9:8]};
			tx   = s[23:16];
			wr(ssm_pkg::OFS_CTRL, {25'h0, rate, dis, sph, s[1], pol});
			wr(ssm_pkg::OFS_BAUD, {24'h0, bd});
			wr(ssm_pkg::OFS_IEN, (i == 3) ? 32'h0 : 32'h3);
			wr(ssm_pkg::OFS_ICLR, 32'h3);
			chk("sck idle", {31'h0, pol}, {31'h0, sck});
			chk("oe_n", {31'h0, dis}, {31'h0, oe_n});
			cke <= s[1];
			stx <= s[31:24];
			frm <= 1'b1;
			wr(ssm_pkg::OFS_BUF, {24'h0, tx});
			if (i == 0) begin
				wr(ssm_pkg::OFS_BUF, {24'h0, ~tx}); // busy, so dropped
			end
			n = 0;
			do begin
				rd(ssm_pkg::OFS_STAT, s);
				n++;
			end while (s[ssm_pkg::STAT_BUSY] !== 1'b0 && n < 500);
			if (n >= 500) begin
				failures++;
				finish_test();
			end
			// the edge monitor sees the last toggle one cycle late
			@(posedge clk_i);
			chk("hresp", 32'h0, {31'h0, hresp});
			chk("stat full", 32'h2, s);
			chk("pulses", 32'd16, tog);
			chk("half bit", half(rate, bd), t2 - t1);
			if (cke) begin
				chk("first bit", {31'h0, tx[7]}, {31'h0, sdo1});
			end
			chk("sck back", {31'h0, pol}, {31'h0, sck});
			chk("irq", {31'h0, i != 3}, {31'h0, irq});
			rd(ssm_pkg::OFS_ISTAT, s);
			chk("istat", {30'h0, i == 0, 1'b1}, s);
			rd(ssm_pkg::OFS_BUF, s);
			chk("rx byte", {24'h0, stx}, s);
			if (!dis) begin
				chk("tx byte", {24'h0, tx}, {24'h0, srx});
			end
			rd(ssm_pkg::OFS_STAT, s);
			chk("full clr", 32'h0, s);
			frm <= 1'b0;
			wr(ssm_pkg::OFS_ICLR, 32'h3);
			rd(ssm_pkg::OFS_ISTAT, s);
			chk("istat clr", 32'h0, s);
			chk("irq clr", 32'h0, {31'h0, irq});
		end
		finish_test();
	end
endmodule
`default_nettype wire
